/* rtl/cvs_pkg.sv */
// constants, field layouts and state types of the core voltage code sequencer
// assumes one 250 MHz clock; codes count 16mV steps above 0.444V
//
// Operation
// (R1) boot selector pattern picks a fixed code, 1.196V at open-gnd-gnd, 0.700V at all-supply
// (R2) at startup the target comes from the boot selector only
// (R3) after power-ok and boot reached, suspend request picks voltage-id or suspend code
// (R4) host raises suspend request; device then ignores voltage-id and slews to suspend code
// (R5) forced continuous PWM through a suspend transition until 62 slew ticks after target
// (R6) with suspend request low the voltage-id bus is followed dynamically
// (R7) power-good and clock-gate frozen during transitions, released 32 ticks after final code
// (R8) active code moves one 16mV step per slew tick
// (R9) rising costs one tick per step, falling two extra ticks
// (R10) slew tick period set by timing input, 1.6us to 15.6us
// (R11) overvoltage shuts down, drops power-good and raises clock-gate at once
// (R12) overvoltage latches low-side drive on until shutdown toggle or supply loss
// (R13) undervoltage latches switching off until shutdown toggle or supply loss
// (R14) undervoltage ignored during transitions and 32 ticks after the final code
// (R15) thermal fault turns low-side on, high-side off, until shutdown toggle
// (R16) no-fault test level disables all three faults and clears their latches
// (R17) four-level inputs arrive as 2-bit values, top input most significant
// (R18) each tick the active code steps one toward the target until equal; the code lets two ticks pass idle at the start of each fall
package cvs_pkg;
	localparam int CODE_W = 7;
	localparam logic [6:0] VID_TOP = 7'h4F;
	localparam logic [6:0] SUS_TOP = 7'h3F;
	localparam logic [6:0] CODE_OFF = 7'h00;
	localparam logic [5:0] BLANK_LAST = 6'h1F;
	localparam logic [5:0] FPWM_LAST = 6'h3D;
	localparam logic [1:0] FALL_EXTRA = 2'h2;
	localparam int CLK_PERIOD_NS = 4;
	localparam int SLEW_MIN_NS = 1600;
	localparam int SLEW_MAX_NS = 15600;
	localparam int SLEW_MIN_CYC = (SLEW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SLEW_MAX_CYC = SLEW_MAX_NS / CLK_PERIOD_NS;
	localparam int SLEW_W = 12;
	localparam logic [11:0] SLEW_MIN = 12'(SLEW_MIN_CYC);
	localparam logic [11:0] SLEW_MAX = 12'(SLEW_MAX_CYC);

	typedef enum logic [1:0] {PH_OFF, PH_BOOT, PH_RUN, PH_SOFT_OFF} phase_t;

	typedef struct packed {
		logic [11:0] slew_period;
		logic [5:0] boot_sel;
		logic [5:0] sus_sel;
		logic [5:0] voltage_id;
		logic suspend_request;
		logic system_power_ok;
		logic run;
		logic no_fault;
		logic ov;
		logic uv;
		logic hot;
	} pins_t;

	typedef struct packed {
		pins_t sync1;
		pins_t sync2;
		phase_t phase;
		logic [11:0] tick_cnt;
		logic tick;
		logic [6:0] code;
		logic [1:0] fall_wait;
		logic [5:0] blank_cnt;
		logic blanked;
		logic [5:0] fpwm_cnt;
		logic fpwm;
		logic sus_prev;
		logic pg;
		logic clk_gate;
		logic ov_latch;
		logic uv_latch;
		logic hot_latch;
		logic pwm_en;
		logic ls_on;
		logic hs_off;
	} state_t;
endpackage

/* rtl/core_voltage_code_sequencer.sv */
// core voltage code sequencer: target selection, slew stepping, blanking, fault latches
// all inputs but clock and reset are pins and pass two flip-flops; supply loss is modelled by arst_n_in
`timescale 1ns/10ps
module core_voltage_code_sequencer (
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic arst_n_in,
	// selectors and voltage-id
	input wire logic [5:0] boot_select_inputs_in,
	input wire logic [5:0] suspend_select_inputs_in,
	input wire logic [5:0] voltage_id_bus_in,
	input wire logic suspend_request_in,
	input wire logic system_power_ok_in,
	// slew period in clock cycles, from the timing resistor
	input wire logic [11:0] slew_timing_resistor_in,
	// shutdown and test level
	input wire logic shutdown_input_in,
	input wire logic no_fault_level_in,
	// analog comparators
	input wire logic overvoltage_protect_in,
	input wire logic undervoltage_protect_in,
	input wire logic thermal_fault_in,
	// outputs
	output logic [6:0] active_code_out,
	output logic core_power_good_out,
	output logic cpu_clock_gate_out,
	output logic forced_pwm_out,
	output logic pwm_enable_out,
	output logic low_side_drive_out,
	output logic high_side_drive_off_out,
	output logic [2:0] fault_latch_out
);

	// a period longer than the counter can hold would wrap the tick count
	if (cvs_pkg::SLEW_MAX_CYC >= (1 << cvs_pkg::SLEW_W)) begin : g_slew_check
		$error("slew counter too narrow");
	end

	cvs_pkg::state_t st;
	cvs_pkg::state_t next_st;
	cvs_pkg::pins_t pins;
	logic [6:0] target;
	logic fault_trip;
	logic at_target;

	////////////////////////////////////////////////////////////////////////////
	assign pins.slew_period = slew_timing_resistor_in;
	assign pins.boot_sel = boot_select_inputs_in;
	assign pins.sus_sel = suspend_select_inputs_in;
	assign pins.voltage_id = voltage_id_bus_in;
	assign pins.suspend_request = suspend_request_in;
	assign pins.system_power_ok = system_power_ok_in;
	assign pins.run = shutdown_input_in;
	assign pins.no_fault = no_fault_level_in;
	assign pins.ov = overvoltage_protect_in;
	assign pins.uv = undervoltage_protect_in;
	assign pins.hot = thermal_fault_in;

	// code = steps above 0.444V; table rows count down from the top code
	always_comb begin
		case (st.phase)
			cvs_pkg::PH_BOOT: target = cvs_pkg::VID_TOP - {1'b0, st.sync2.boot_sel}; // [R1] [R2] [R17]
			cvs_pkg::PH_RUN: begin
				if (st.sync2.suspend_request) begin
					target = cvs_pkg::SUS_TOP - {1'b0, st.sync2.sus_sel}; // [R3] [R4]
				end else begin
					target = cvs_pkg::VID_TOP - {1'b0, st.sync2.voltage_id}; // [R6]
				end
			end
			default: target = cvs_pkg::CODE_OFF;
		endcase
	end

	assign at_target = (st.code == target);

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [11:0] period;
		logic ov_set;
		logic uv_set;
		logic hot_set;
		logic clear;
		period = st.sync2.slew_period;
		ov_set = 1'b0;
		uv_set = 1'b0;
		hot_set = 1'b0;
		clear = 1'b0;
		next_st = st;
		next_st.sync1 = pins;
		next_st.sync2 = st.sync1;

		// timing input clamped to the usable range [R10]
		if (period < cvs_pkg::SLEW_MIN) begin
			period = cvs_pkg::SLEW_MIN;
		end else if (period > cvs_pkg::SLEW_MAX) begin
			period = cvs_pkg::SLEW_MAX;
		end
		next_st.tick = 1'b0;
		if (st.tick_cnt >= period - 12'h001) begin
			next_st.tick_cnt = 12'h000;
			next_st.tick = 1'b1; // [R10]
		end else begin
			next_st.tick_cnt = st.tick_cnt + 12'h001;
		end

		// stepping; falling waits two ticks first for resynchronisation
		if (st.tick) begin
			if (st.code < target) begin
				next_st.code = st.code + 7'h01; // [R8] [R9] [R18]
				next_st.fall_wait = 2'h0;
			end else if (st.code > target) begin
				if (st.fall_wait < cvs_pkg::FALL_EXTRA) begin
					next_st.fall_wait = st.fall_wait + 2'h1; // [R9]
				end else begin
					next_st.code = st.code - 7'h01; // [R8] [R18]
				end
			end else begin
				next_st.fall_wait = 2'h0;
			end
		end else if (st.code <= target) begin
			// every falling run restarts its idle ticks, even one right after a fall
			next_st.fall_wait = 2'h0; // [R9]
		end

		// blanking window: transition plus 32 ticks
		if (!at_target) begin
			next_st.blanked = 1'b1; // [R7] [R14]
			next_st.blank_cnt = 6'h00;
		end else if (st.blanked && st.tick) begin
			if (st.blank_cnt == cvs_pkg::BLANK_LAST) begin
				next_st.blanked = 1'b0; // [R7] [R14]
			end else begin
				next_st.blank_cnt = st.blank_cnt + 6'h01;
			end
		end

		// forced pwm held 62 ticks past arrival at the suspend-change target
		next_st.sus_prev = st.sync2.suspend_request;
		if (st.phase == cvs_pkg::PH_RUN && st.sync2.suspend_request != st.sus_prev) begin
			next_st.fpwm = 1'b1; // [R5]
			next_st.fpwm_cnt = 6'h00;
		end else if (st.fpwm && at_target && st.tick) begin
			if (st.fpwm_cnt == cvs_pkg::FPWM_LAST) begin
				next_st.fpwm = 1'b0; // [R5]
			end else begin
				next_st.fpwm_cnt = st.fpwm_cnt + 6'h01;
			end
		end else if (!at_target) begin
			next_st.fpwm_cnt = 6'h00;
		end

		// fault latches; a set in the clearing cycle still wins
		if (!st.sync2.no_fault) begin
			ov_set = st.sync2.ov; // [R11]
			uv_set = st.sync2.uv && st.phase == cvs_pkg::PH_RUN && !st.blanked; // [R13] [R14]
			hot_set = st.sync2.hot; // [R15]
		end
		clear = !st.sync2.run || st.sync2.no_fault; // [R12] [R16]
		next_st.ov_latch = ov_set || (st.ov_latch && !clear);
		next_st.uv_latch = uv_set || (st.uv_latch && !clear);
		next_st.hot_latch = hot_set || (st.hot_latch && !clear);

		// phase sequencing
		case (st.phase)
			cvs_pkg::PH_OFF: begin
				if (st.sync2.run && !st.ov_latch && !st.uv_latch && !st.hot_latch) begin
					next_st.phase = cvs_pkg::PH_BOOT;
				end
			end
			cvs_pkg::PH_BOOT: begin
				if (!st.sync2.run) begin
					next_st.phase = cvs_pkg::PH_SOFT_OFF;
				end else if (at_target && !st.blanked && st.sync2.system_power_ok) begin
					next_st.phase = cvs_pkg::PH_RUN; // [R3]
				end
			end
			cvs_pkg::PH_RUN: begin
				if (!st.sync2.run) begin
					next_st.phase = cvs_pkg::PH_SOFT_OFF;
				end
			end
			cvs_pkg::PH_SOFT_OFF: begin
				if (st.code == cvs_pkg::CODE_OFF) begin
					next_st.phase = cvs_pkg::PH_OFF;
				end
			end
			default: next_st.phase = cvs_pkg::PH_OFF;
		endcase
		if (next_st.ov_latch || next_st.uv_latch || next_st.hot_latch) begin
			next_st.phase = cvs_pkg::PH_OFF; // [R13]
			next_st.code = cvs_pkg::CODE_OFF;
		end

		// status outputs frozen while blanked, except overvoltage which acts at once
		if (next_st.ov_latch) begin
			next_st.pg = 1'b0; // [R11]
			next_st.clk_gate = 1'b1;
		end else if (!st.blanked) begin
			next_st.pg = st.phase == cvs_pkg::PH_RUN && st.sync2.system_power_ok; // [R7]
			next_st.clk_gate = !next_st.pg;
		end

		next_st.pwm_en = next_st.phase != cvs_pkg::PH_OFF; // [R13]
		next_st.ls_on = next_st.ov_latch || next_st.hot_latch; // [R12] [R15]
		next_st.hs_off = next_st.ls_on || !next_st.pwm_en; // [R15]
	end

	assign fault_trip = next_st.ov_latch || next_st.uv_latch || next_st.hot_latch;

	always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st <= '0;
			st.clk_gate <= 1'b1;
			st.hs_off <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign active_code_out = st.code;
	assign core_power_good_out = st.pg;
	assign cpu_clock_gate_out = st.clk_gate;
	assign forced_pwm_out = st.fpwm;
	assign pwm_enable_out = st.pwm_en;
	assign low_side_drive_out = st.ls_on;
	assign high_side_drive_off_out = st.hs_off;
	assign fault_latch_out = {st.hot_latch, st.uv_latch, st.ov_latch};

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (!arst_n_in);

	chk_boot_decode: assert property ( // [R1]
		st.phase == cvs_pkg::PH_BOOT |-> target == 7'h4F - {1'b0, st.sync2.boot_sel})
		else $error("boot target mismatch");

	chk_suspend_select: assert property ( // [R4]
		st.phase == cvs_pkg::PH_RUN && st.sync2.suspend_request |-> target == 7'h3F - {1'b0, st.sync2.sus_sel})
		else $error("suspend target mismatch");

	chk_vid_follow: assert property ( // [R6]
		st.phase == cvs_pkg::PH_RUN && !st.sync2.suspend_request |-> target == 7'h4F - {1'b0, st.sync2.voltage_id})
		else $error("voltage-id target mismatch");

	chk_step_on_tick: assert property ( // [R8]
		st.code != $past(st.code) && !$past(fault_trip) |-> $past(st.tick))
		else $error("code changed without tick");

	chk_rise_step: assert property ( // [R9]
		st.tick && st.code < target && !fault_trip |=> st.code == $past(st.code) + 7'h01)
		else $error("rising step missed");

	chk_fall_delay: assert property ( // [R9]
		st.tick && st.code > target && st.fall_wait == 2'h0 && !fault_trip |=> $stable(st.code))
		else $error("falling step too early");

	chk_tick_spacing: assert property ( // [R10]
		st.tick |=> !st.tick [*8])
		else $error("slew ticks too close");

	chk_blank_freeze: assert property ( // [R7]
		st.blanked && !next_st.ov_latch |=> $stable(st.pg) && $stable(st.clk_gate))
		else $error("status moved while blanked");

	chk_ov_response: assert property ( // [R11]
		st.sync2.ov && !st.sync2.no_fault |=> !st.pg && st.clk_gate && st.ls_on && !st.pwm_en)
		else $error("overvoltage response wrong");

	chk_uv_masked: assert property ( // [R14]
		st.blanked && !st.uv_latch |=> !st.uv_latch)
		else $error("undervoltage seen while masked");

	chk_uv_off: assert property ( // [R13]
		st.uv_latch |-> !st.pwm_en)
		else $error("switching with undervoltage latch");

	chk_thermal_drive: assert property ( // [R15]
		st.hot_latch |-> st.ls_on && st.hs_off)
		else $error("thermal drive wrong");

	chk_no_fault_clear: assert property ( // [R16]
		st.sync2.no_fault |=> !st.ov_latch && !st.uv_latch && !st.hot_latch)
		else $error("latch held in test mode");

	chk_fpwm_start: assert property ( // [R5]
		st.phase == cvs_pkg::PH_RUN && st.sync2.suspend_request != st.sus_prev |=> st.fpwm)
		else $error("forced pwm not raised");

	chk_fall_restart: assert property ( // [R9]
		at_target |=> st.fall_wait == 2'h0)
		else $error("falling run skipped its idle ticks");

	chk_ov_hold: assert property ( // [R12]
		st.ov_latch && st.sync2.run && !st.sync2.no_fault |=> st.ov_latch)
		else $error("overvoltage latch dropped");

	cov_boot_run: cover property (st.phase == cvs_pkg::PH_BOOT ##1 st.phase == cvs_pkg::PH_RUN);
	cov_suspend: cover property (st.fpwm ##1 !st.fpwm);
	cov_ov_trip: cover property (!st.ov_latch ##1 st.ov_latch);
	cov_uv_trip: cover property (!st.uv_latch ##1 st.uv_latch);
	cov_soft_off: cover property (st.phase == cvs_pkg::PH_SOFT_OFF ##1 st.phase == cvs_pkg::PH_OFF);

endmodule

/* dv/cvs_partner.sv */
// partner model: host logic and power stage feeding the sequencer's pins
// assumes bench commands are levels; pins change just after the rising edge
`timescale 1ns/10ps
module cvs_partner (
	// clock
	input wire logic sys_clk_in,
	// bench commands
	input wire logic [2:0] fault_cmd_in,
	input wire logic sus_cmd_in,
	input wire logic run_cmd_in,
	// pins toward the sequencer
	output logic suspend_request_out,
	output logic shutdown_input_out,
	output logic [2:0] comparator_out
);
	// comparators report a fault only when the bench orders one
	always @(posedge sys_clk_in) begin
		suspend_request_out <= sus_cmd_in;
		shutdown_input_out <= run_cmd_in;
		comparator_out <= fault_cmd_in;
	end
endmodule

/* dv/core_voltage_code_sequencer_tb_top.sv */
// testbench: boot, voltage-id following, suspend, fault latches
// assumes slew period 400 cycles; partner adds one cycle to command latency
`timescale 1ns/10ps
module core_voltage_code_sequencer_tb_top;
	localparam int TK = 400;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [5:0] boot_sel = 6'h00;
	logic [5:0] sus_sel = 6'h00;
	logic [5:0] voltage_id = 6'h00;
	logic pok = 1'b0;
	logic nofault = 1'b0;
	logic [2:0] fault_cmd = 3'h0;
	logic sus_cmd = 1'b0;
	logic run_cmd = 1'b0;
	logic suspend_request, shutdown_input;
	logic [2:0] cmp;
	logic [6:0] code;
	logic pg, cg, fpwm, ls, hs_off;
	logic [2:0] latch;
	logic pwm;
	// below the usable range on purpose: the period clamps to TK cycles
	logic [11:0] slew_timing_resistor = 12'h064;
	int bad_count = 0;
	int n_compared = 0;
	int n;
	////////////////////////////////////////////////////////////////
	initial begin
		forever #2 clk = ~clk;
	end
	cvs_partner far (.sys_clk_in(clk), .fault_cmd_in(fault_cmd), .sus_cmd_in(sus_cmd),
		.run_cmd_in(run_cmd), .suspend_request_out(suspend_request), .shutdown_input_out(shutdown_input),
		.comparator_out(cmp));
	core_voltage_code_sequencer uut (.sys_clk_in(clk), .arst_n_in(rst_n),
		.boot_select_inputs_in(boot_sel), .suspend_select_inputs_in(sus_sel),
		.voltage_id_bus_in(voltage_id), .suspend_request_in(suspend_request), .system_power_ok_in(pok),
		.slew_timing_resistor_in(slew_timing_resistor), .shutdown_input_in(shutdown_input),
		.no_fault_level_in(nofault), .overvoltage_protect_in(cmp[0]),
		.undervoltage_protect_in(cmp[1]), .thermal_fault_in(cmp[2]),
		.active_code_out(code), .core_power_good_out(pg), .cpu_clock_gate_out(cg),
		.forced_pwm_out(fpwm), .pwm_enable_out(pwm), .low_side_drive_out(ls),
		.high_side_drive_off_out(hs_off), .fault_latch_out(latch));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [6:0] exp, input logic [6:0] got);
		n_compared++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// bounded wait so a stuck sequencer ends in the watchdog, not a hang
	task automatic wait_code(input logic [6:0] c, output int w);
		w = 0;
		while (code !== c && w < 30000) begin
			cyc(1);
			w++;
		end
	endtask
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (90000) @(posedge clk);
		bad_count++;
		close_out();
	end
	initial begin
		cyc(5);
		chk("reset gate", 7'h01, {6'h00, cg});
		chk("reset hs off", 7'h01, {6'h00, hs_off});
		chk("reset code", 7'h00, code);
		@(posedge clk);
		rst_n <= 1'b1;
		boot_sel <= 6'h20;
		voltage_id <= 6'h20;
		pok <= 1'b1;
		run_cmd <= 1'b1;
		fault_cmd <= 3'h2;
		cyc(4);
		@(posedge clk);
		fault_cmd <= 3'h0;
		cyc(4);
		chk("uv blanked", 7'h00, {4'h0, latch});
		wait_code(7'h2F, n);
		chk("boot code", 7'h2F, code);
		chk("boot time", 7'h01, 7'(n > 45 * TK && n <= 48 * TK));
		chk("pg blanked", 7'h00, {6'h00, pg});
		cyc(31 * TK);
		chk("pg still blanked", 7'h00, {6'h00, pg});
		cyc(TK + 10);
		chk("pg up", 7'h01, {6'h00, pg});
		chk("gate open", 7'h00, {6'h00, cg});
		chk("run pwm on", 7'h01, {6'h00, pwm});
		$display("test boot done");
		@(posedge clk);
		voltage_id <= 6'h1F;
		wait_code(7'h30, n);
		chk("rise time", 7'h01, 7'(n <= TK + 8));
		chk("pg frozen", 7'h01, {6'h00, pg});
		@(posedge clk);
		voltage_id <= 6'h20;
		wait_code(7'h2F, n);
		chk("fall time", 7'h01, 7'(n > 2 * TK && n <= 3 * TK + 8));
		$display("test voltage id done");
		@(posedge clk);
		sus_sel <= 6'h11;
		sus_cmd <= 1'b1;
		cyc(6);
		chk("forced pwm on", 7'h01, {6'h00, fpwm});
		@(posedge clk);
		voltage_id <= 6'h00;
		wait_code(7'h2E, n);
		chk("suspend time", 7'h01, 7'(n > 2 * TK && n <= 3 * TK + 8));
		cyc(60 * TK);
		chk("forced pwm held", 7'h01, {6'h00, fpwm});
		cyc(3 * TK);
		chk("forced pwm off", 7'h00, {6'h00, fpwm});
		chk("vid ignored", 7'h2E, code);
		$display("test suspend done");
		@(posedge clk);
		fault_cmd <= 3'h2;
		cyc(6);
		chk("uv latch", 7'h02, {4'h0, latch});
		chk("uv pwm off", 7'h00, {6'h00, pwm});
		chk("uv code off", 7'h00, code);
		$display("test undervoltage done");
		@(posedge clk);
		fault_cmd <= 3'h1;
		cyc(6);
		chk("ov pg", 7'h00, {6'h00, pg});
		chk("ov gate", 7'h01, {6'h00, cg});
		chk("ov low side", 7'h01, {6'h00, ls});
		@(posedge clk);
		fault_cmd <= 3'h0;
		cyc(10);
		chk("ov latch", 7'h03, {4'h0, latch});
		@(posedge clk);
		run_cmd <= 1'b0;
		cyc(6);
		chk("ov cleared", 7'h00, {4'h0, latch});
		$display("test overvoltage done");
		@(posedge clk);
		fault_cmd <= 3'h4;
		cyc(6);
		chk("hot low side", 7'h01, {6'h00, ls});
		chk("hot hs off", 7'h01, {6'h00, hs_off});
		chk("hot latch", 7'h04, {4'h0, latch});
		@(posedge clk);
		nofault <= 1'b1;
		cyc(6);
		chk("test clears", 7'h00, {4'h0, latch});
		@(posedge clk);
		fault_cmd <= 3'h1;
		cyc(6);
		chk("test masks", 7'h00, {4'h0, latch});
		$display("test faults done");
		close_out();
	end
endmodule
